/* File: core/spf_pin_mux.sv */
// pin-function multiplexer and port registers of the dsp memory companion
`timescale 1ns/1ns

// Function
// - Low byte-space select from the dsp selects the byte-wide memory.
// - Active-low reset clears port registers and configuration state to defaults.
// - Byte data port carries dsp data lines eight to fifteen.
// - Second-port pins: dsp i/o, macrocell output or logic input.
// - Second-port pins 0..3 select standard or fast slew at run time.
// - Second-port pins 3..7 select push-pull or open-drain at run time.
// - Third-port pins: dsp i/o, shared macrocell output or logic input.
// - Third-port pins 0,1,5,6 may carry scan mode, clock, data in, out.
// - Third-port pins 3,4 may carry scan status and scan error outputs.
// - Third-port pin 3 may show flash ready/busy level.
// - Third-port general i/o pins select push-pull or open-drain.
// - Scan pins share their pins with other functions.
// - Fourth-port pins: dsp i/o, direct logic input or chip-select output.
// - Fourth-port pin 1 may serve as common logic clock input.
// - Fourth-port pin 2 may be active-low flash select; high disables flash.
// - Dsp write and read strobes, active low, qualify register accesses.
// - Control registers take 256 i/o locations; upper data byte ignored.
module spf_pin_mux
   import spf_pkg::*;
(
   input  wire logic                clk,
   input  wire logic                reset_n,
   input  wire logic                write_strobe_in_n,
   input  wire logic                read_strobe_in_n,
   input  wire logic                byte_space_select_in_n,
   input  wire logic                io_space_select_n,
   input  wire logic [7:0]          io_addr,
   input  wire logic [7:0]          byte_data_port_i,
   output logic      [7:0]          byte_data_port_o,
   output logic                     byte_data_port_oe_n,
   input  wire spf_cfg_t            cfg,
   input  wire logic [SPF_PB_W-1:0] first_output_macrocells,
   input  wire logic [SPF_PB_W-1:0] shared_output_macrocells,
   input  wire logic [SPF_PD_W-1:0] ext_chip_select,
   input  wire logic                scan_tdo,
   input  wire logic                scan_tdo_en,
   input  wire logic                scan_status_out,
   input  wire logic                scan_error_out,
   input  wire logic                flash_ready,
   input  wire logic [SPF_PB_W-1:0] second_port_pins_i,
   output logic      [SPF_PB_W-1:0] second_port_pins_o,
   output logic      [SPF_PB_W-1:0] second_port_pins_oe_n,
   output logic      [3:0]          second_port_fast_slew,
   input  wire logic [SPF_PC_W-1:0] third_port_pins_i,
   output logic      [SPF_PC_W-1:0] third_port_pins_o,
   output logic      [SPF_PC_W-1:0] third_port_pins_oe_n,
   input  wire logic [SPF_PD_W-1:0] fourth_port_pins_i,
   output logic      [SPF_PD_W-1:0] fourth_port_pins_o,
   output logic      [SPF_PD_W-1:0] fourth_port_pins_oe_n,
   output logic      [SPF_PB_W-1:0] logic_in_b,
   output logic      [SPF_PC_W-1:0] logic_in_c,
   output logic      [SPF_PD_W-1:0] logic_in_d,
   output logic                     logic_common_clock,
   output logic                     scan_tms,
   output logic                     scan_tck,
   output logic                     scan_tdi,
   output logic                     flash_select_n
);

   // one pin: {level, enable_n}; open drain only ever pulls low
   function automatic logic [1:0] spf_pin_drive(input spf_func_t fn, input logic dout,
                                                input logic dir, input logic mc,
                                                input logic od);
      logic drive;
      logic val;
      drive = (fn == SPF_FN_MCELL_OUT) || ((fn == SPF_FN_MCU_IO) && dir);
      val   = (fn == SPF_FN_MCELL_OUT) ? mc : dout;
      if (od)
         spf_pin_drive = {1'b0, !(drive && !val)};
      else
         spf_pin_drive = {val, !drive};
   endfunction : spf_pin_drive

   spf_bus_t            bus_s1_r;
   spf_bus_t            bus_s2_r;
   logic                wr_prev_r;
   logic [18:0]         pin_s1_r;
   logic [18:0]         pin_s2_r;
   spf_cfg_t            cfg_r;
   logic [7:0]          pb_out_r;
   logic [7:0]          pb_dir_r;
   logic [7:0]          pc_out_r;
   logic [7:0]          pc_dir_r;
   logic [2:0]          pd_out_r;
   logic [2:0]          pd_dir_r;
   logic [7:0]          pb_in;
   logic [7:0]          pc_in;
   logic [2:0]          pd_in;
   logic                wr_event;
   logic                rd_active;
   logic [7:0]          rd_data_nxt;
   logic [7:0]          pb_o_nxt;
   logic [7:0]          pb_oe_n_nxt;
   logic [7:0]          pc_o_nxt;
   logic [7:0]          pc_oe_n_nxt;
   logic [2:0]          pd_o_nxt;
   logic [2:0]          pd_oe_n_nxt;
   logic                flash_sel_n_nxt;

   // two-flop synchronisers for dsp bus and pin inputs
   always_ff @(posedge clk)
   begin
      if (!reset_n)
      begin
         bus_s1_r <= SPF_BUS_IDLE;
         bus_s2_r <= SPF_BUS_IDLE;
         pin_s1_r <= '0;
         pin_s2_r <= '0;
      end
      else
      begin
         bus_s1_r <= '{wr_n: write_strobe_in_n, rd_n: read_strobe_in_n,
                       bs_n: byte_space_select_in_n, io_n: io_space_select_n,
                       addr: io_addr, data: byte_data_port_i};
         bus_s2_r <= bus_s1_r;
         pin_s1_r <= {fourth_port_pins_i, third_port_pins_i, second_port_pins_i};
         pin_s2_r <= pin_s1_r;
      end
   end

   assign pb_in = pin_s2_r[7:0];
   assign pc_in = pin_s2_r[15:8];
   assign pd_in = pin_s2_r[18:16];

   // strobe decode: write lands at the rising edge of the write strobe
   always_ff @(posedge clk)
   begin
      if (!reset_n)
         wr_prev_r <= 1'b1;
      else
         wr_prev_r <= bus_s2_r.wr_n;
   end

   assign wr_event  = bus_s2_r.wr_n && !wr_prev_r && !bus_s2_r.io_n;
   assign rd_active = !bus_s2_r.rd_n && !bus_s2_r.io_n;

   // configuration held in state, defaults after reset
   always_ff @(posedge clk)
   begin
      if (!reset_n)
         cfg_r <= SPF_CFG_RST;
      else
         cfg_r <= cfg;
   end

   // port data and direction registers, written from i/o space
   always_ff @(posedge clk)
   begin
      if (!reset_n)
      begin
         pb_out_r <= SPF_PORT_RST;
         pb_dir_r <= SPF_PORT_RST;
         pc_out_r <= SPF_PORT_RST;
         pc_dir_r <= SPF_PORT_RST;
         pd_out_r <= SPF_PD_RST;
         pd_dir_r <= SPF_PD_RST;
      end
      else if (wr_event)
      begin
         // full 8-bit offset space; only the byte lane d8..d15 is seen
         unique case (bus_s2_r.addr)
            SPF_OFS_PB_OUT: pb_out_r <= bus_s2_r.data;
            SPF_OFS_PB_DIR: pb_dir_r <= bus_s2_r.data;
            SPF_OFS_PC_OUT: pc_out_r <= bus_s2_r.data;
            SPF_OFS_PC_DIR: pc_dir_r <= bus_s2_r.data;
            SPF_OFS_PD_OUT: pd_out_r <= bus_s2_r.data[2:0];
            SPF_OFS_PD_DIR: pd_dir_r <= bus_s2_r.data[2:0];
            default: ;
         endcase
      end
   end

   // read mux over the register block, unmapped offsets read zero
   always_comb
   begin
      unique case (bus_s2_r.addr)
         SPF_OFS_PB_OUT: rd_data_nxt = pb_out_r;
         SPF_OFS_PB_DIR: rd_data_nxt = pb_dir_r;
         SPF_OFS_PC_OUT: rd_data_nxt = pc_out_r;
         SPF_OFS_PC_DIR: rd_data_nxt = pc_dir_r;
         SPF_OFS_PD_OUT: rd_data_nxt = {5'h00, pd_out_r};
         SPF_OFS_PD_DIR: rd_data_nxt = {5'h00, pd_dir_r};
         SPF_OFS_PB_IN:  rd_data_nxt = pb_in;
         SPF_OFS_PC_IN:  rd_data_nxt = pc_in;
         SPF_OFS_PD_IN:  rd_data_nxt = {5'h00, pd_in};
         default:        rd_data_nxt = 8'h00;
      endcase
   end

   // byte data port drive during qualified reads
   always_ff @(posedge clk)
   begin
      if (!reset_n)
      begin
         byte_data_port_o    <= 8'h00;
         byte_data_port_oe_n <= 1'b1;
      end
      else
      begin
         byte_data_port_o    <= rd_data_nxt;
         byte_data_port_oe_n <= !rd_active;
      end
   end

   // pin output selection per port
   always_comb
   begin
      for (int i = 0; i < SPF_PB_W; i++)
      begin
         // open drain only for pins 3..7
         {pb_o_nxt[i], pb_oe_n_nxt[i]} = spf_pin_drive(cfg_r.pb_func[i], pb_out_r[i],
            pb_dir_r[i], cfg_r.pb_shared[i] ? shared_output_macrocells[i]
            : first_output_macrocells[i], (i >= 3) ? cfg_r.pb_od[(i >= 3) ? i - 3 : 0]
            : 1'b0);
      end
      for (int i = 0; i < SPF_PC_W; i++)
      begin
         {pc_o_nxt[i], pc_oe_n_nxt[i]} = spf_pin_drive(cfg_r.pc_func[i], pc_out_r[i],
            pc_dir_r[i], shared_output_macrocells[i], cfg_r.pc_od[i]);
      end
      // scan functions override the pin's own function while enabled
      if (cfg_r.jtag_en)
      begin
         pc_oe_n_nxt[SPF_PC_TMS] = 1'b1;
         pc_oe_n_nxt[SPF_PC_TCK] = 1'b1;
         pc_oe_n_nxt[SPF_PC_TDI] = 1'b1;
         pc_o_nxt[SPF_PC_TDO]    = scan_tdo;
         pc_oe_n_nxt[SPF_PC_TDO] = !scan_tdo_en;
      end
      if (cfg_r.jtag_en && cfg_r.jtag_ext_en)
      begin
         pc_o_nxt[SPF_PC_STAT]    = scan_status_out;
         pc_oe_n_nxt[SPF_PC_STAT] = 1'b0;
         pc_o_nxt[SPF_PC_ERR]     = scan_error_out;
         pc_oe_n_nxt[SPF_PC_ERR]  = 1'b0;
      end
      else if (cfg_r.rdybsy_en)
      begin
         pc_o_nxt[SPF_PC_STAT]    = flash_ready;
         pc_oe_n_nxt[SPF_PC_STAT] = 1'b0;
      end
      for (int i = 0; i < SPF_PD_W; i++)
      begin
         {pd_o_nxt[i], pd_oe_n_nxt[i]} = spf_pin_drive(cfg_r.pd_func[i], pd_out_r[i],
            pd_dir_r[i], ext_chip_select[i], 1'b0);
      end
      if (cfg_r.comclk_en)
         pd_oe_n_nxt[SPF_PD_CLK] = 1'b1;
      if (cfg_r.csi_en)
         pd_oe_n_nxt[SPF_PD_CSI] = 1'b1;
   end

   // flash select from byte space, gated by the low-power select input
   assign flash_sel_n_nxt = bus_s2_r.bs_n ||
                            (cfg_r.csi_en && pd_in[SPF_PD_CSI]);

   // registered pin and select outputs
   always_ff @(posedge clk)
   begin
      if (!reset_n)
      begin
         second_port_pins_o    <= '0;
         second_port_pins_oe_n <= '1;
         second_port_fast_slew <= 4'h0;
         third_port_pins_o     <= '0;
         third_port_pins_oe_n  <= '1;
         fourth_port_pins_o    <= '0;
         fourth_port_pins_oe_n <= '1;
         flash_select_n        <= 1'b1;
      end
      else
      begin
         second_port_pins_o    <= pb_o_nxt;
         second_port_pins_oe_n <= pb_oe_n_nxt;
         second_port_fast_slew <= cfg_r.pb_slew;
         third_port_pins_o     <= pc_o_nxt;
         third_port_pins_oe_n  <= pc_oe_n_nxt;
         fourth_port_pins_o    <= pd_o_nxt;
         fourth_port_pins_oe_n <= pd_oe_n_nxt;
         flash_select_n        <= flash_sel_n_nxt;
      end
   end

   // synchronised pin levels into the programmable logic
   assign logic_in_b         = pb_in;
   assign logic_in_c         = pc_in;
   assign logic_in_d         = pd_in;
   assign logic_common_clock = cfg_r.comclk_en && pd_in[SPF_PD_CLK];
   assign scan_tms           = cfg_r.jtag_en && pc_in[SPF_PC_TMS];
   assign scan_tck           = cfg_r.jtag_en && pc_in[SPF_PC_TCK];
   assign scan_tdi           = cfg_r.jtag_en && pc_in[SPF_PC_TDI];

   // checks
   a_reset_clears: assert property (@(posedge clk)
      !reset_n |=> (pb_out_r == 8'h00) && (pc_dir_r == 8'h00) && (cfg_r == SPF_CFG_RST))
      else $error("reset did not clear port state");
   a_byte_select: assert property (@(posedge clk) disable iff (!reset_n)
      (!bus_s2_r.bs_n && !cfg_r.csi_en) |=> !flash_select_n)
      else $error("byte select did not select flash");
   a_csi_power: assert property (@(posedge clk) disable iff (!reset_n)
      (cfg_r.csi_en && pd_in[SPF_PD_CSI]) |=> flash_select_n)
      else $error("flash not disabled by high select input");
   a_read_drive: assert property (@(posedge clk) disable iff (!reset_n)
      (!bus_s2_r.rd_n && !bus_s2_r.io_n && bus_s2_r.addr == SPF_OFS_PB_OUT)
      |=> !byte_data_port_oe_n && byte_data_port_o == $past(pb_out_r))
      else $error("read did not return register");
   a_write_store: assert property (@(posedge clk) disable iff (!reset_n)
      (wr_event && bus_s2_r.addr == SPF_OFS_PC_DIR) |=> pc_dir_r == $past(bus_s2_r.data))
      else $error("write not stored");
   a_input_float: assert property (@(posedge clk) disable iff (!reset_n)
      cfg_r.pb_func[0] == SPF_FN_LOGIC_IN |=> second_port_pins_oe_n[0])
      else $error("logic input pin is driven");
   a_scan_inputs: assert property (@(posedge clk) disable iff (!reset_n)
      cfg_r.jtag_en |=> third_port_pins_oe_n[SPF_PC_TMS] && third_port_pins_oe_n[SPF_PC_TDI])
      else $error("scan input pin is driven");
   a_ready_busy: assert property (@(posedge clk) disable iff (!reset_n)
      (cfg_r.rdybsy_en && !cfg_r.jtag_en) |=> !third_port_pins_oe_n[SPF_PC_STAT]
      && third_port_pins_o[SPF_PC_STAT] == $past(flash_ready))
      else $error("ready/busy level not shown");
   a_od_low_only: assert property (@(posedge clk) disable iff (!reset_n)
      ($past(cfg_r.pc_od[2]) && !cfg_r.jtag_en && !third_port_pins_oe_n[2])
      |-> !third_port_pins_o[2])
      else $error("open drain pin drove high");
   a_slew_follow: assert property (@(posedge clk) disable iff (!reset_n)
      ##1 $stable(cfg_r.pb_slew) |=> second_port_fast_slew == $past(cfg_r.pb_slew))
      else $error("slew control not applied");
   a_clock_in: assert property (@(posedge clk) disable iff (!reset_n)
      cfg_r.comclk_en |=> fourth_port_pins_oe_n[SPF_PD_CLK])
      else $error("clock input pin is driven");

   c_io_write: cover property (@(posedge clk) disable iff (!reset_n) wr_event);
   c_io_read: cover property (@(posedge clk) disable iff (!reset_n) rd_active);
   c_flash_sel: cover property (@(posedge clk) disable iff (!reset_n) !flash_select_n);
   c_scan_ext: cover property (@(posedge clk) disable iff (!reset_n)
      cfg_r.jtag_en && cfg_r.jtag_ext_en);

endmodule : spf_pin_mux

/* File: core/spf_pkg.sv */
// package: pin-function constants, configuration and bus carriers
package spf_pkg;

   // port widths
   localparam int SPF_PB_W = 8;
   localparam int SPF_PC_W = 8;
   localparam int SPF_PD_W = 3;

   // control register block offsets, low address byte in i/o space
   localparam logic [7:0] SPF_OFS_PB_OUT = 8'h00;
   localparam logic [7:0] SPF_OFS_PB_DIR = 8'h01;
   localparam logic [7:0] SPF_OFS_PC_OUT = 8'h02;
   localparam logic [7:0] SPF_OFS_PC_DIR = 8'h03;
   localparam logic [7:0] SPF_OFS_PD_OUT = 8'h04;
   localparam logic [7:0] SPF_OFS_PD_DIR = 8'h05;
   localparam logic [7:0] SPF_OFS_PB_IN  = 8'h06;
   localparam logic [7:0] SPF_OFS_PC_IN  = 8'h07;
   localparam logic [7:0] SPF_OFS_PD_IN  = 8'h08;

   // values after reset
   localparam logic [7:0] SPF_PORT_RST = 8'h00;
   localparam logic [2:0] SPF_PD_RST   = 3'h0;

   // scan pin positions of the third port
   localparam int SPF_PC_TMS  = 0;
   localparam int SPF_PC_TCK  = 1;
   localparam int SPF_PC_STAT = 3;
   localparam int SPF_PC_ERR  = 4;
   localparam int SPF_PC_TDI  = 5;
   localparam int SPF_PC_TDO  = 6;
   // fourth port special pins
   localparam int SPF_PD_CLK  = 1;
   localparam int SPF_PD_CSI  = 2;

   // per-pin function choice
   typedef enum logic [1:0] {
      SPF_FN_MCU_IO,
      SPF_FN_MCELL_OUT,
      SPF_FN_LOGIC_IN
   } spf_func_t;

   // run-time configuration of all pins
   typedef struct packed {
      spf_func_t [SPF_PB_W-1:0] pb_func;
      spf_func_t [SPF_PC_W-1:0] pc_func;
      spf_func_t [SPF_PD_W-1:0] pd_func;
      logic [SPF_PB_W-1:0]      pb_shared;   // port b pin uses shared macrocell group
      logic [3:0]               pb_slew;     // fast slew, pins 0..3
      logic [4:0]               pb_od;       // open drain, pins 3..7
      logic [SPF_PC_W-1:0]      pc_od;       // open drain, general i/o
      logic                     jtag_en;
      logic                     jtag_ext_en;
      logic                     rdybsy_en;
      logic                     comclk_en;
      logic                     csi_en;
   } spf_cfg_t;

   localparam spf_cfg_t SPF_CFG_RST = '0;

   // dsp bus inputs, sampled together
   typedef struct packed {
      logic       wr_n;
      logic       rd_n;
      logic       bs_n;
      logic       io_n;
      logic [7:0] addr;
      logic [7:0] data;
   } spf_bus_t;

   localparam spf_bus_t SPF_BUS_IDLE = '{wr_n: 1'b1, rd_n: 1'b1, bs_n: 1'b1,
                                          io_n: 1'b1, addr: 8'h00, data: 8'h00};

endpackage : spf_pkg

/* File: test/spf_dsp_model.sv */
// dsp bus model: strobes, selects, address and data towards the companion
`timescale 1ns/1ns
module spf_dsp_model
   import spf_pkg::*;
(
   input  wire logic       clk,
   input  wire logic [7:0] rdata,
   input  wire logic       rdata_oe_n,
   output spf_bus_t        bus
);
   // idle bus from power-up, byte select included
   initial bus = SPF_BUS_IDLE;

   // i/o write: strobe low four cycles, address and data held past release
   task automatic io_write(input logic [7:0] a, input logic [7:0] d);
      @(negedge clk);
      bus.io_n = 1'b0;
      bus.addr = a;
      bus.data = d; // only the low data byte exists here
      bus.wr_n = 1'b0;
      repeat (4) @(negedge clk);
      bus.wr_n = 1'b1;
      repeat (4) @(negedge clk);
      bus.io_n = 1'b1;
      bus.data = ~d; // released lines show no stale value
   endtask : io_write

   // i/o read: wait a bounded time for the device to drive
   task automatic io_read(input logic [7:0] a, output logic [7:0] d, output bit ok);
      ok = 1'b0;
      d = 8'h00;
      @(negedge clk);
      bus.io_n = 1'b0;
      bus.addr = a;
      bus.rd_n = 1'b0;
      for (int i = 0; i < 12 && !ok; i++)
      begin
         @(posedge clk);
         ok = (rdata_oe_n === 1'b0);
         d = rdata;
      end
      @(negedge clk);
      bus.rd_n = 1'b1;
      repeat (4) @(negedge clk);
      bus.io_n = 1'b1;
   endtask : io_read
endmodule : spf_dsp_model

/* File: test/spf_pin_mux_bench.sv */
// self-checking bench for the pin-function multiplexer
`timescale 1ns/1ns
module spf_pin_mux_bench import spf_pkg::*;;
   logic        clk, reset_n, doe_n, tdo, tdo_en, stat, err, fr, lclk, tms, tck, tdi, fsel_n;
   spf_cfg_t    cfg;
   spf_bus_t    bus;
   logic [7:0]  mc_a, mc_s, pb_i, pc_i, dout, pb_o, pb_oe, pc_o, pc_oe, lib, lic, rdv;
   logic [7:0]  out_b, dir_b, out_c, dir_c;
   logic [3:0]  slew;
   logic [2:0]  ecs, pd_i, pd_o, pd_oe, lid, out_d, dir_d;
   logic [15:0] e;
   integer      seed;
   int          fails, checks;

   // clock, 50 ns period
   initial
   begin
      clk = 1'b0;
      forever #25 clk = ~clk;
   end

   spf_pin_mux u_dut (.clk(clk), .reset_n(reset_n), .write_strobe_in_n(bus.wr_n),
      .read_strobe_in_n(bus.rd_n), .byte_space_select_in_n(bus.bs_n),
      .io_space_select_n(bus.io_n), .io_addr(bus.addr), .byte_data_port_i(bus.data),
      .byte_data_port_o(dout), .byte_data_port_oe_n(doe_n), .cfg(cfg),
      .first_output_macrocells(mc_a), .shared_output_macrocells(mc_s), .ext_chip_select(ecs),
      .scan_tdo(tdo), .scan_tdo_en(tdo_en), .scan_status_out(stat), .scan_error_out(err),
      .flash_ready(fr), .second_port_pins_i(pb_i), .second_port_pins_o(pb_o),
      .second_port_pins_oe_n(pb_oe), .second_port_fast_slew(slew), .third_port_pins_i(pc_i),
      .third_port_pins_o(pc_o), .third_port_pins_oe_n(pc_oe), .fourth_port_pins_i(pd_i),
      .fourth_port_pins_o(pd_o), .fourth_port_pins_oe_n(pd_oe), .logic_in_b(lib),
      .logic_in_c(lic), .logic_in_d(lid), .logic_common_clock(lclk), .scan_tms(tms),
      .scan_tck(tck), .scan_tdi(tdi), .flash_select_n(fsel_n));

   spf_dsp_model u_dsp (.clk(clk), .rdata(dout), .rdata_oe_n(doe_n), .bus(bus));

   task automatic check(input string name, input logic [7:0] seen, input logic [7:0] exp);
      checks++;
      if (seen !== exp)
      begin
         fails++;
         $display("Error %s expected %h seen %h", name, exp, seen);
      end
   endtask : check

   task automatic test_done;
      $display("checks %0d fails %0d", checks, fails);
      if (fails == 0 && checks > 0)
         $display("[ PASS ]");
      else
         $display("[ FAIL ]");
      $finish;
   endtask : test_done

   task automatic rd_reg(input logic [7:0] a);
      bit ok;
      u_dsp.io_read(a, rdv, ok);
      if (!ok)
      begin
         fails++;
         test_done;
      end
   endtask : rd_reg

   task automatic settle;
      repeat (6) @(negedge clk);
   endtask : settle

   // expected {oe_n, level} of eight pins from function, sources and registers
   function automatic logic [15:0] exp_pins(input logic [15:0] f, input logic [7:0] mc, od,
                                            dir, out);
      logic [15:0] r;
      r = 16'hff00;
      for (int i = 0; i < 8; i++)
      begin
         r[i] = (f[2*i +: 2] == SPF_FN_MCELL_OUT) ? mc[i] : out[i];
         if (f[2*i +: 2] == SPF_FN_MCELL_OUT || (f[2*i +: 2] == SPF_FN_MCU_IO && dir[i]))
            r[8+i] = od[i] & r[i];
      end
      return r;
   endfunction : exp_pins

   // hang guard
   initial
   begin
      #2000000;
      fails++;
      test_done;
   end

   // main sequence
   initial
   begin
      seed = 6063;
      reset_n = 1'b0; // low from power-up
      cfg = SPF_CFG_RST;
      {mc_a, mc_s, pb_i, pc_i, ecs, pd_i, tdo, tdo_en, stat, err, fr} = '0;
      repeat (12) @(negedge clk);
      check("pb_oe", pb_oe, 8'hff);
      check("pc_oe", pc_oe, 8'hff);
      check("pd_oe", pd_oe, 8'h07);
      check("slew_fsel_doe", {slew, fsel_n, doe_n}, 8'h03);
      reset_n = 1'b1;
      // every data and direction register written and read back, then an unmapped place
      for (int k = 0; k < 6; k++)
      begin
         e[7:0] = 8'($random(seed)) & ((k > 3) ? 8'h07 : 8'hff);
         u_dsp.io_write(k[7:0], e[7:0]);
         rd_reg(k[7:0]);
         check("reg", rdv, e[7:0]);
      end
      u_dsp.io_write(8'h3c, 8'ha5);
      rd_reg(8'h3c);
      check("unmapped", rdv, 8'h00);
      // random pin functions, sources and port registers
      for (int n = 0; n < 16; n++)
      begin
         @(negedge clk);
         {cfg.pb_shared, cfg.pb_slew, cfg.pb_od, cfg.pc_od} = 25'($random(seed));
         for (int i = 0; i < 8; i++)
         begin
            cfg.pb_func[i] = spf_func_t'($unsigned($random(seed)) % 3);
            cfg.pc_func[i] = spf_func_t'($unsigned($random(seed)) % 3);
            if (cfg.pc_func[i] != SPF_FN_MCU_IO)
               cfg.pc_od[i] = 1'b0;
            if (i > 2 && cfg.pb_func[i] != SPF_FN_MCU_IO)
               cfg.pb_od[i-3] = 1'b0;
         end
         for (int i = 0; i < 3; i++)
            cfg.pd_func[i] = spf_func_t'($unsigned($random(seed)) % 3);
         {mc_a, mc_s, pb_i, pc_i} = $random(seed);
         {ecs, pd_i, out_d, dir_d} = 12'($random(seed));
         {out_b, dir_b, out_c, dir_c} = $random(seed);
         u_dsp.io_write(SPF_OFS_PB_OUT, out_b);
         u_dsp.io_write(SPF_OFS_PB_DIR, dir_b);
         u_dsp.io_write(SPF_OFS_PC_OUT, out_c);
         u_dsp.io_write(SPF_OFS_PC_DIR, dir_c);
         u_dsp.io_write(SPF_OFS_PD_OUT, {5'h0, out_d});
         u_dsp.io_write(SPF_OFS_PD_DIR, {5'h0, dir_d});
         settle;
         e = exp_pins(cfg.pb_func, (mc_s & cfg.pb_shared) | (mc_a & ~cfg.pb_shared),
                      {cfg.pb_od, 3'b000}, dir_b, out_b);
         check("pb_oe", pb_oe, e[15:8]);
         check("pb_o", pb_o & ~e[15:8], e[7:0] & ~e[15:8]);
         check("slew", slew, cfg.pb_slew);
         check("lib", lib, pb_i);
         e = exp_pins(cfg.pc_func, mc_s, cfg.pc_od, dir_c, out_c);
         check("pc_oe", pc_oe, e[15:8]);
         check("pc_o", pc_o & ~e[15:8], e[7:0] & ~e[15:8]);
         check("lic", lic, pc_i);
         e = exp_pins({10'h0, cfg.pd_func}, {5'h0, ecs}, 8'h00, {5'h0, dir_d}, {5'h0, out_d});
         check("pd_oe", pd_oe, e[10:8]);
         check("pd_o", pd_o & ~e[10:8], e[2:0] & ~e[10:8]);
         check("lid", lid, pd_i);
         rd_reg(SPF_OFS_PB_IN);
         check("pb_in", rdv, pb_i);
         rd_reg(SPF_OFS_PC_IN);
         check("pc_in", rdv, pc_i);
         rd_reg(SPF_OFS_PD_IN);
         check("pd_in", rdv, {5'h0, pd_i});
      end
      // scan pins take over the third port, then give it back
      u_dsp.io_write(SPF_OFS_PC_DIR, 8'h00);
      cfg = SPF_CFG_RST;
      cfg.jtag_en = 1'b1;
      {tdo, tdo_en, stat, err, fr} = 5'h1b;
      pc_i = $random(seed);
      settle;
      check("scan_in", {tms, tck, tdi}, {pc_i[0], pc_i[1], pc_i[5]});
      check("tdo", {pc_oe[6], pc_o[6]}, 2'b01);
      cfg.jtag_ext_en = 1'b1;
      settle;
      check("stat_err", {pc_oe[4:3], pc_o[4:3]}, {2'b00, err, stat});
      cfg = SPF_CFG_RST;
      cfg.rdybsy_en = 1'b1;
      for (int k = 0; k < 2; k++)
      begin
         fr = k[0];
         settle;
         check("ready", {pc_oe[3], pc_o[3]}, {1'b0, fr});
      end
      cfg.rdybsy_en = 1'b0;
      settle;
      check("pc_free", {tms, pc_oe[3]}, 2'b01);
      // byte select, flash select input and their shared enable in all combinations, common clock alongside
      for (int k = 0; k < 8; k++)
      begin
         cfg.csi_en = k[2];
         cfg.comclk_en = k[2];
         pd_i = {k[1], k[0] ^ k[1], 1'b0}; // pin 2 as flash select input
         u_dsp.bus.bs_n = k[0];
         settle;
         check("fsel_n", fsel_n, k[0] | (k[2] & k[1]));
         check("lclk", lclk, k[2] & pd_i[1]);
      end
      // reset in mid-run clears the port registers again
      u_dsp.io_write(SPF_OFS_PB_OUT, 8'h5a);
      reset_n = 1'b0;
      repeat (4) @(negedge clk);
      reset_n = 1'b1;
      rd_reg(SPF_OFS_PB_OUT);
      check("rst_reg", rdv, 8'h00);
      test_done;
   end
endmodule : spf_pin_mux_bench
